// ===== inc/spf_regs.svh
// Constants for the serial PROM fetch port
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

// PROM geometry: word address and word data widths
`define SPF_ADDR_W    22
`define SPF_WORD_W    16
`define SPF_FETCH_W   32

// Port clock cycles spent shifting in each phase
`define SPF_SHIFT_LEN 22

// Divider select width: half period is select plus one core cycles
`define SPF_DIV_SEL_W 3

// Second word address offset from the first
`define SPF_ADDR_STEP 1

`endif

// ===== inc/spf_pkg.sv
// Types shared by the serial PROM fetch port
package spf_pkg;

	// Fetch sequencer phases: idle, then one per strobe-low or strobe-high stretch
	typedef enum logic [3:0] {
		SPF_IDLE,
		SPF_SH_A1,
		SPF_LD_A1,
		SPF_SH_A2,
		SPF_LD_A2,
		SPF_SH_D1,
		SPF_LD_D1,
		SPF_SH_D2,
		SPF_LD_D2
	} spf_state_e;

endpackage

// ===== rtl/spf_clkdiv.sv
// Port clock divider with edge ticks for the PROM fetch port
`timescale 1ns/1ps
`default_nettype none
`include "spf_regs.svh"

module spf_clkdiv #(
	parameter int SEL_W = `SPF_DIV_SEL_W
) (
	// Clock and control
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             ce,
	// Ratio select: divisor is 2 * (div_sel + 1)
	input  wire logic [SEL_W-1:0] div_sel,
	// Divided clock and edge ticks
	output logic                  port_clk,
	output logic                  rise_tick,
	output logic                  fall_tick
);

	logic [SEL_W-1:0] cnt_reg;
	logic             wrap;

	// Half period ends when the counter meets the select value
	assign wrap      = (cnt_reg >= div_sel);
	assign rise_tick = wrap && !port_clk;
	assign fall_tick = wrap && port_clk;

	// Half period counter
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_reg <= '0;
		end else if (ce) begin
			cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
		end
	end

	// Port clock toggles each half period, 1/2 to 1/16 of core rate
	always_ff @(posedge clk) begin
		if (srst) begin
			port_clk <= 1'b0;
		end else if (ce && wrap) begin
			port_clk <= !port_clk;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/spf_fetch_port.sv
// Serial PROM fetch port: two pipelined word reads per 32-bit fetch
`timescale 1ns/1ps
`default_nettype none
`include "spf_regs.svh"

module spf_fetch_port #(
	parameter int ADDR_W = `SPF_ADDR_W,
	parameter int WORD_W = `SPF_WORD_W,
	parameter int SEL_W  = `SPF_DIV_SEL_W
) (
	// Clock, reset, enable
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	// Configuration
	input  wire logic [SEL_W-1:0]      div_sel,
	input  wire logic                  low_speed_sel,
	// Fetch request and answer
	input  wire logic                  req_valid,
	input  wire logic [ADDR_W-1:0]     word_address,
	output logic                       req_ready,
	output logic                       fetch_done,
	output logic [2*WORD_W-1:0]        fetch_result_register,
	// PROM port pins
	input  wire logic                  prom_serial_in,
	output logic                       prom_serial_out,
	output logic                       load_shift_strobe,
	output logic                       prom_port_clock
);

	localparam int                LEN_W    = $clog2(`SPF_SHIFT_LEN);
	localparam logic [LEN_W-1:0]  LAST_BIT = LEN_W'(`SPF_SHIFT_LEN - 1);
	localparam logic [ADDR_W-1:0] STEP     = ADDR_W'(`SPF_ADDR_STEP);

	spf_pkg::spf_state_e state_reg;
	logic [LEN_W-1:0]    bit_cnt_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic [ADDR_W-1:0]   addr_next;
	logic [ADDR_W-1:0]   out_sr_reg;
	logic [ADDR_W-1:0]   in_sr_reg;
	logic                pend_reg;
	logic                sin_meta_reg;
	logic                sin_sync_reg;
	logic                rise_tick;
	logic                fall_tick;
	logic                rise;
	logic                fall;
	logic                last_bit;
	logic                shifting;

	// Port clock generation
	spf_clkdiv #(
		.SEL_W     (SEL_W)
	) u_div (
		.clk       (clk),
		.srst      (srst),
		.ce        (ce),
		.div_sel   (div_sel),
		.port_clk  (prom_port_clock),
		.rise_tick (rise_tick),
		.fall_tick (fall_tick)
	);

	// Qualified edge events and phase helpers
	assign rise     = ce && rise_tick;
	assign fall     = ce && fall_tick;
	assign last_bit = (bit_cnt_reg == LAST_BIT);
	assign addr_next = addr_reg + STEP;
	assign shifting = (state_reg == spf_pkg::SPF_SH_A1) ||
	                  (state_reg == spf_pkg::SPF_SH_A2) ||
	                  (state_reg == spf_pkg::SPF_SH_D1) ||
	                  (state_reg == spf_pkg::SPF_SH_D2);

	// Serial input synchroniser
	always_ff @(posedge clk) begin
		if (srst) begin
			sin_meta_reg <= 1'b0;
			sin_sync_reg <= 1'b0;
		end else if (ce) begin
			sin_meta_reg <= prom_serial_in;
			sin_sync_reg <= sin_meta_reg;
		end
	end

	// Request capture, accepted only while idle
	always_ff @(posedge clk) begin
		if (srst) begin
			pend_reg <= 1'b0;
			addr_reg <= '0;
		end else if (ce) begin
			if (req_valid && req_ready) begin
				pend_reg <= 1'b1;
				addr_reg <= word_address;
			end else if (fall && state_reg == spf_pkg::SPF_IDLE) begin
				pend_reg <= 1'b0;
			end
		end
	end

	// Ready is shown only with no fetch pending or running
	always_ff @(posedge clk) begin
		if (srst) begin
			req_ready <= 1'b0;
		end else if (ce) begin
			req_ready <= state_reg == spf_pkg::SPF_IDLE && !pend_reg &&
			             !(req_valid && req_ready);
		end
	end

	// Phase sequencer, steps on falling port clock edges
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg   <= spf_pkg::SPF_IDLE;
			bit_cnt_reg <= '0;
		end else if (fall) begin
			// Wraps at the last bit so the count never leaves 0..21
			bit_cnt_reg <= (shifting && !last_bit) ? bit_cnt_reg + 1'b1 : '0;
			case (state_reg)
				spf_pkg::SPF_IDLE: begin
					if (pend_reg) begin
						state_reg <= spf_pkg::SPF_SH_A1;
					end
				end
				spf_pkg::SPF_SH_A1: begin
					if (last_bit) begin
						state_reg <= spf_pkg::SPF_LD_A1;
					end
				end
				spf_pkg::SPF_LD_A1: state_reg <= spf_pkg::SPF_SH_A2;
				spf_pkg::SPF_SH_A2: begin
					if (last_bit) begin
						state_reg <= spf_pkg::SPF_LD_A2;
					end
				end
				spf_pkg::SPF_LD_A2: state_reg <= spf_pkg::SPF_SH_D1;
				spf_pkg::SPF_SH_D1: begin
					if (last_bit) begin
						state_reg <= spf_pkg::SPF_LD_D1;
					end
				end
				spf_pkg::SPF_LD_D1: state_reg <= spf_pkg::SPF_SH_D2;
				spf_pkg::SPF_SH_D2: begin
					if (last_bit) begin
						state_reg <= spf_pkg::SPF_LD_D2;
					end
				end
				spf_pkg::SPF_LD_D2: state_reg <= spf_pkg::SPF_IDLE;
				default:            state_reg <= spf_pkg::SPF_IDLE;
			endcase
		end
	end

	// Strobe: low while shifting, one port-clock-cycle pulse between, idle shows mode
	always_ff @(posedge clk) begin
		if (srst) begin
			load_shift_strobe <= 1'b0;
		end else if (ce) begin
			if (state_reg == spf_pkg::SPF_IDLE && !(fall && pend_reg)) begin
				load_shift_strobe <= low_speed_sel;
			end else if (fall) begin
				load_shift_strobe <= shifting && last_bit;
			end
		end
	end

	// Address shifter, MSB first, changes on falling edges
	always_ff @(posedge clk) begin
		if (srst) begin
			out_sr_reg      <= '0;
			prom_serial_out <= 1'b0;
		end else if (fall) begin
			if (state_reg == spf_pkg::SPF_IDLE && pend_reg) begin
				prom_serial_out <= addr_reg[ADDR_W-1];
				out_sr_reg      <= addr_reg << 1;
			end else if (state_reg == spf_pkg::SPF_LD_A1) begin
				// Second address starts with its own top bit, 22 bits in all
				prom_serial_out <= addr_next[ADDR_W-1];
				out_sr_reg      <= addr_next << 1;
			end else begin
				prom_serial_out <= out_sr_reg[ADDR_W-1];
				out_sr_reg      <= out_sr_reg << 1;
			end
		end
	end

	// Data capture on rising edges, one board-shifted bit per port cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			in_sr_reg <= '0;
		end else if (rise) begin
			in_sr_reg <= {in_sr_reg[ADDR_W-2:0], sin_sync_reg};
		end
	end

	// Return-data register and completion pulse
	always_ff @(posedge clk) begin
		if (srst) begin
			fetch_result_register <= '0;
			fetch_done            <= 1'b0;
		end else if (ce) begin
			fetch_done <= 1'b0;
			if (rise && state_reg == spf_pkg::SPF_LD_D1) begin
				fetch_result_register[WORD_W-1:0] <=
					in_sr_reg[WORD_W-1:0];
			end
			if (rise && state_reg == spf_pkg::SPF_LD_D2) begin
				fetch_result_register[2*WORD_W-1:WORD_W] <=
					in_sr_reg[WORD_W-1:0];
				fetch_done <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Checks next to the sequencer
	AST_SHIFT_LOW: assert property (shifting && $past(shifting) |->
		!load_shift_strobe) else $error("strobe high while shifting");
	AST_LOAD_HIGH: assert property (
		$rose(load_shift_strobe) && state_reg != spf_pkg::SPF_IDLE |->
		$past(fall && shifting && last_bit))
		else $error("load pulse not after last shift bit");
	AST_CNT_RANGE: assert property (bit_cnt_reg <= LAST_BIT)
		else $error("bit counter out of range");
	AST_IDLE_MODE: assert property (
		ce && state_reg == spf_pkg::SPF_IDLE && !pend_reg ##1
		state_reg == spf_pkg::SPF_IDLE |->
		load_shift_strobe == $past(low_speed_sel))
		else $error("idle strobe does not show protocol select");
	AST_DONE_CAUSE: assert property (fetch_done |->
		$past(rise && state_reg == spf_pkg::SPF_LD_D2) ||
		$past(fetch_done && !ce))
		else $error("done without final load");
	AST_TAKE_IDLE: assert property (req_valid && req_ready && ce |=>
		pend_reg && !req_ready) else $error("request not taken");
	AST_FIRST_BIT: assert property (
		fall && state_reg == spf_pkg::SPF_IDLE && pend_reg |=>
		prom_serial_out == $past(addr_reg[ADDR_W-1]) &&
		state_reg == spf_pkg::SPF_SH_A1)
		else $error("first address bit wrong");
	AST_LOW_WORD: assert property (
		rise && state_reg == spf_pkg::SPF_LD_D1 |=>
		fetch_result_register[WORD_W-1:0] == $past(in_sr_reg[WORD_W-1:0]))
		else $error("first word not stored");
	AST_CLK_EDGE: assert property ($rose(prom_port_clock) |->
		$past(rise)) else $error("port clock rose without tick");
	AST_SECOND_ADDR: assert property (
		fall && state_reg == spf_pkg::SPF_LD_A1 |=>
		out_sr_reg == ($past(addr_reg) + STEP) << 1 &&
		prom_serial_out == $past(addr_reg + STEP) >> (ADDR_W - 1))
		else $error("second address not loaded");

	// Main scenarios
	COV_DONE:   cover property (fetch_done);
	COV_LOWSPD: cover property (state_reg == spf_pkg::SPF_IDLE &&
		load_shift_strobe);
	COV_MDIO:   cover property (state_reg == spf_pkg::SPF_IDLE &&
		!load_shift_strobe);
	COV_SLOW:   cover property (fetch_done && div_sel == '1);

endmodule
`default_nettype wire

// ===== bench/spf_prom_model.sv
// Board shift register, presentation register and PROM for the fetch port
`timescale 1ns/1ps
`default_nettype none
module spf_prom_model (
	// Port pins driven by the device
	input  wire logic prom_port_clock,
	input  wire logic load_shift_strobe,
	input  wire logic prom_serial_out,
	// Serial data back to the device
	output logic      prom_serial_in
);
	logic [21:0] shift_reg = 22'h2A_5A5A;
	logic [21:0] present_reg = 22'h00_0000;

	// PROM contents are a fixed scramble of the word address
	function automatic logic [15:0] rom_word(input logic [21:0] a);
		return a[15:0] ^ {a[21:16], 10'h000} ^ 16'h5A3C;
	endfunction

	// Load on a strobe-high rise, otherwise shift one bit in
	always @(posedge prom_port_clock) begin
		if (load_shift_strobe) begin
			present_reg <= shift_reg;
			shift_reg   <= {6'h2B, rom_word(present_reg)};
		end else begin
			shift_reg <= {shift_reg[20:0], prom_serial_out};
		end
	end

	// Device reads the top bit of the board shift register
	assign prom_serial_in = shift_reg[21];
endmodule
`default_nettype wire

// ===== bench/tb_spf_fetch_port.sv
// Self-checking bench for the serial PROM fetch port
`timescale 1ns/1ps
`default_nettype none
module tb_spf_fetch_port;
	logic        clk;
	logic        srst;
	logic        ce;
	logic [2:0]  div_sel;
	logic        low_speed_sel;
	logic        req_valid;
	logic [21:0] word_address;
	logic        req_ready;
	logic        fetch_done;
	logic [31:0] fetch_result_register;
	logic        prom_serial_in;
	logic        prom_serial_out;
	logic        load_shift_strobe;
	logic        prom_port_clock;
	int          num_errors = 0;
	int          checked = 0;
	integer      seed;
	logic [31:0] exp_q[$];
	int          half_cnt = 0;
	int          run_len = 0;
	int          pulses = 0;
	logic        pc_prev = 0;
	logic        ce_prev = 0;
	logic        armed = 0;
	logic        done_prev = 0;
	logic        rdy_prev = 0;
	logic        framing = 0;

	spf_fetch_port dut_u (.clk, .srst, .ce, .div_sel, .low_speed_sel,
		.req_valid, .word_address, .req_ready, .fetch_done,
		.fetch_result_register, .prom_serial_in, .prom_serial_out,
		.load_shift_strobe, .prom_port_clock);
	spf_prom_model board_u (.prom_port_clock, .load_shift_strobe,
		.prom_serial_out, .prom_serial_in);

	// Core clock at 10 MHz
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	function automatic logic [15:0] exp_word(input logic [21:0] a);
		return a[15:0] ^ {a[21:16], 10'h000} ^ 16'h5A3C;
	endfunction

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	// One fetch; poke holds a second request and jitters ce while busy
	task automatic fetch(input logic [21:0] a, input bit poke);
		int n;
		step();
		req_valid = 1'b1;
		word_address = a;
		while (req_ready !== 1'b1 || ce !== 1'b1) step();
		@(posedge clk);
		exp_q.push_back({exp_word(a + 22'h00_0001), exp_word(a)});
		#1;
		req_valid = 1'b0;
		if (poke) begin
			step();
			req_valid = 1'b1;
			word_address = ~a;
			for (n = 0; n < 40; n++) begin
				ce = ($random(seed) % 4) != 0;
				step();
				check("busy ready", {31'h0, req_ready}, 32'h0);
			end
			ce = 1'b1;
			req_valid = 1'b0;
		end
		n = 0;
		while (req_ready !== 1'b1 && n < 5000) begin
			step();
			n++;
		end
		// A fetch that never returns counts as a mismatch
		if (n >= 5000) num_errors++;
	endtask

	// Port clock timing, strobe runs and completed fetches
	always @(negedge clk) begin
		if (ce_prev) half_cnt++;
		if (prom_port_clock !== pc_prev) begin
			if (armed) check("half period", half_cnt, div_sel + 32'd1);
			armed = (req_ready === 1'b0);
			half_cnt = 0;
			// Frame starts at the first fall after the take edge
			if (prom_port_clock === 1'b0 && req_ready === 1'b0 &&
					rdy_prev === 1'b0)
				framing = 1'b1;
			if (prom_port_clock === 1'b1 && framing) begin
				if (load_shift_strobe === 1'b0) begin
					run_len++;
				end else if (run_len > 0) begin
					check("low run", run_len, 32'd22);
					pulses++;
					run_len = 0;
				end
			end
		end
		if (fetch_done === 1'b1 && done_prev !== 1'b1) begin
			check("ready at done", {31'h0, req_ready}, 32'h0);
			check("pulses", pulses, 32'd4);
			check("queued", exp_q.size(), 32'd1);
			if (exp_q.size() > 0)
				check("result", fetch_result_register, exp_q.pop_front());
		end
		if (req_ready === 1'b1) begin
			armed = 1'b0;
			framing = 1'b0;
			run_len = 0;
			pulses = 0;
		end
		rdy_prev = req_ready;
		done_prev = fetch_done;
		pc_prev = prom_port_clock;
		ce_prev = ce;
	end

	// Watchdog sized well above the longest expected run
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		int k;
		seed = 87710;
		srst = 1'b1;
		ce = 1'b1;
		div_sel = 3'h1;
		low_speed_sel = 1'b1;
		req_valid = 1'b0;
		word_address = 22'h00_0000;
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		// Idle strobe level follows the protocol select
		for (int i = 0; i < 2; i++) begin
			low_speed_sel = i[0];
			k = 0;
			while (load_shift_strobe !== i[0] && k < 40) begin
				step();
				k++;
			end
			check("idle strobe", {31'h0, load_shift_strobe}, {31'h0, i[0]});
			$display("test idle_strobe_%0d done", i);
		end
		// Every divide ratio from four to sixteen
		for (int d = 1; d < 8; d++) begin
			div_sel = d[2:0];
			low_speed_sel = 1'($random(seed));
			fetch(22'($random(seed)), 1'b0);
			$display("test divide_%0d done", d);
		end
		fetch(22'h3F_FFFF, 1'b0);
		$display("test address_wrap done");
		div_sel = 3'h2;
		fetch(22'($random(seed)), 1'b1);
		fetch(22'($random(seed)), 1'b0);
		$display("test busy_refusal done");
		repeat (5) step();
		check("left over", exp_q.size(), 32'd0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
